// >>> srwc_detect.sv
/*
 * Position detector: compares the reference pulse as seen at every delayed
 * tap and publishes a hazard vector once enough rising edges were seen.
 * Assumes tap samples are synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module srwc_detect
	import srwc_pkg::*;
#(
	parameter int NPOS = srwc_pkg::NUM_POS
) (
	// Clock and reset
	input  wire logic            ref_clk,
	input  wire logic            resetn,
	// Tap samples
	input  wire logic [NPOS-1:0] tap_samples,
	// Result
	output logic      [NPOS-1:0] ref_position_vector,
	output logic                 pos_valid
);
	import srwc_pkg::*;

	if (NPOS < 3) begin : g_bad_npos
		$error("srwc_detect: NPOS must be at least 3");
	end

	typedef struct packed {
		logic [NPOS-1:0] acc;
		logic [NPOS-1:0] vec;
		logic [1:0]      edges;
		logic            valid;
		logic            prev0;
		logic [3:0]      rises;
	} srwc_det_t;

	srwc_det_t st_reg, st_next;
	logic [NPOS-1:0] hazard;
	logic            rise;

	// Position next to a sample mismatch sits on the pulse edge
	function automatic logic [NPOS-1:0] edge_flags(input logic [NPOS-1:0] s);
		logic [NPOS-1:0] d;
		d = '0;
		for (int i = 0; i < NPOS - 1; i++) begin
			if (s[i] != s[i+1]) begin
				d[i]   = 1'b1;
				d[i+1] = 1'b1;
			end
		end
		return d;
	endfunction

	always_comb begin
		st_next = st_reg;
		hazard  = edge_flags(tap_samples);
		rise    = tap_samples[0] & ~st_reg.prev0;
		st_next.prev0 = tap_samples[0];
		st_next.acc   = st_reg.acc | hazard;
		// Saturating count of all rises, watched by the validity check
		if (rise && st_reg.rises != 4'hf) begin
			st_next.rises = st_reg.rises + 4'h1;
		end
		if (rise) begin
			if (st_reg.edges == EDGES_VALID - 2'h1) begin
				// Publish and restart, so the vector tracks drift
				st_next.vec   = st_reg.acc | hazard;
				st_next.vec[0]      = 1'b1;
				st_next.vec[NPOS-1] = 1'b1;
				st_next.valid = 1'b1;
				st_next.edges = 2'h0;
				st_next.acc   = '0;
			end else begin
				st_next.edges = st_reg.edges + 2'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '{acc: '0, vec: '1, edges: 2'h0, valid: 1'b0, prev0: 1'b0, rises: 4'h0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign ref_position_vector = st_reg.vec;
	assign pos_valid           = st_reg.valid;

	a_valid_needs_edges: assert property (@(posedge ref_clk) disable iff (!resetn)
		pos_valid |-> st_reg.rises >= 4'h3)
		else $error("position vector valid before three rising edges");

	a_end_bits_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		ref_position_vector[0] && ref_position_vector[NPOS-1])
		else $error("end positions of vector not flagged");

	a_publish_hazard: assert property (@(posedge ref_clk) disable iff (!resetn)
		(rise && st_reg.edges == 2'h2) |=> ((ref_position_vector & $past(hazard)) == $past(hazard)))
		else $error("hazard seen at publish edge missing from vector");
endmodule // srwc_detect
`default_nettype wire

// >>> srwc_pkg.sv
/*
 * Constants for the reference-pulse window capture block: register map,
 * field positions, reset values and detector counts.
 * Assumes a single 10 MHz clock domain and an APB register bus.
 */
`default_nettype none
package srwc_pkg;
	localparam int          NUM_POS      = 24;
	localparam int          SEL_POS      = 16;
	localparam int          SEL_W        = 4;
	localparam logic [1:0]  EDGES_VALID  = 2'h3;
	// Register byte addresses
	localparam logic [11:0] OFS_CTRL     = 12'h000;
	localparam logic [11:0] OFS_STATUS   = 12'h004;
	// Control register fields
	localparam int          CTRL_SEL_LSB = 0;
	localparam int          CTRL_FINE    = 4;
	localparam int          CTRL_SINGLE  = 5;
	// Status register fields
	localparam int          STAT_VALID   = 24;
	// Reset values
	localparam logic [3:0]  RST_SEL      = 4'h0;
	localparam logic        RST_FINE     = 1'b0;
	localparam logic        RST_SINGLE   = 1'b0;
endpackage
`default_nettype wire

// >>> srwc_ref_gen.sv
/*
 * Reference pulse source: drives the pulse as seen at every delayed tap,
 * periodic with an edge that lands between two chosen taps.
 * Assumes the bench sets the edge position and a run enable.
 */
`timescale 1ns/1ps
`default_nettype none
module srwc_ref_gen (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Control
	input  wire logic        run,
	input  wire logic [4:0]  edge_pos,
	// Tap samples
	output logic      [23:0] tap_rise,
	output logic      [23:0] tap_fall
);
	logic [2:0]  phase_reg;
	logic [23:0] late_mask;
	assign late_mask = 24'hFF_FFFF << edge_pos;
	// Same picture on the falling edge keeps single-channel capture checkable
	assign tap_fall = tap_rise;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			phase_reg <= 3'h0;
			tap_rise  <= 24'h00_0000;
		end else begin
			// Fixed period, so every rise lands on the same tap boundary
			phase_reg <= run ? phase_reg + 3'h1 : 3'h0;
			case (phase_reg)
				3'h0: tap_rise <= run ? late_mask : 24'h00_0000;
				3'h4: tap_rise <= ~late_mask;
				3'h1, 3'h2, 3'h3: tap_rise <= 24'hFF_FFFF;
				default: tap_rise <= 24'h00_0000;
			endcase
		end
	end
endmodule // srwc_ref_gen
`default_nettype wire

// >>> srwc_top.sv
/*
 * Reference-pulse window capture top: APB registers, tap selection and
 * capture of the reference pulse at the chosen delayed position.
 * Assumes an external delay line delivers the pulse sampled at every tap,
 * for the rising and the falling clock edge, synchronous to ref_clk.
 */
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module srwc_top
	import srwc_pkg::*;
#(
	parameter int NPOS = srwc_pkg::NUM_POS,
	parameter int NSEL = srwc_pkg::SEL_POS
) (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   resetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Delay line
	input  wire logic [NPOS-1:0]        tap_rise,
	input  wire logic [NPOS-1:0]        tap_fall,
	output logic                        ref_step_fine,
	output logic [srwc_pkg::SEL_W-1:0]  ref_sample_select,
	// Captured reference
	output logic                        ref_captured,
	output logic                        ref_capture_fall
);
	import srwc_pkg::*;

	// Status word holds the vector below the valid bit
	if (NSEL != (1 << SEL_W) || NPOS <= NSEL || NPOS > STAT_VALID) begin : g_bad_size
		$error("srwc_top: unsupported NPOS/NSEL");
	end

	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic             fine;
		logic             single;
		logic             ready;
		logic             slverr;
		logic [31:0]      rdata;
		logic             cap;
		logic             cap_fall;
	} srwc_top_t;

	srwc_top_t st_reg, st_next;
	logic [NPOS-1:0] pos_vec;
	logic            pos_valid;
	logic            access;
	logic            hit_ctrl;
	logic            hit_stat;

	srwc_detect #(
		.NPOS(NPOS)
	) u_detect (
		.ref_clk             (ref_clk),
		.resetn              (resetn),
		.tap_samples         (tap_rise),
		.ref_position_vector (pos_vec),
		.pos_valid           (pos_valid)
	);

	always_comb begin
		st_next  = st_reg;
		access   = psel & penable & ~st_reg.ready;
		hit_ctrl = (paddr == OFS_CTRL);
		hit_stat = (paddr == OFS_STATUS);
		st_next.ready  = access;
		st_next.slverr = access & ~hit_ctrl & ~hit_stat;
		st_next.rdata  = 32'h0000_0000;
		if (access && !pwrite) begin
			if (hit_ctrl) begin
				st_next.rdata[CTRL_SEL_LSB +: SEL_W] = st_reg.sel;
				st_next.rdata[CTRL_FINE]             = st_reg.fine;
				st_next.rdata[CTRL_SINGLE]           = st_reg.single;
			end else if (hit_stat) begin
				// Plain read, detector state untouched
				st_next.rdata[NPOS-1:0] = pos_vec;
				st_next.rdata[STAT_VALID] = pos_valid;
			end
		end
		if (access && pwrite && hit_ctrl) begin
			// Field is four bits wide, positions above 15 unreachable
			st_next.sel    = pwdata[CTRL_SEL_LSB +: SEL_W];
			st_next.fine   = pwdata[CTRL_FINE];
			st_next.single = pwdata[CTRL_SINGLE];
		end
		// Registered on ref_clk so capture edge is fixed after reset
		st_next.cap      = tap_rise[st_reg.sel];
		st_next.cap_fall = st_reg.single & tap_fall[st_reg.sel];
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '{sel: RST_SEL, fine: RST_FINE, single: RST_SINGLE, ready: 1'b0,
				slverr: 1'b0, rdata: 32'h0000_0000, cap: 1'b0, cap_fall: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata            = st_reg.rdata;
	assign pready            = st_reg.ready;
	assign pslverr           = st_reg.slverr;
	assign ref_step_fine     = st_reg.fine;
	assign ref_sample_select = st_reg.sel;
	assign ref_captured      = st_reg.cap;
	assign ref_capture_fall  = st_reg.cap_fall;

	sequence s_ctrl_write;
		psel && penable && pwrite && !pready && paddr == OFS_CTRL;
	endsequence

	sequence s_status_read;
		psel && penable && !pwrite && !pready && paddr == OFS_STATUS;
	endsequence

	a_sel_follows_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_ctrl_write |=> ref_sample_select == $past(pwdata[CTRL_SEL_LSB +: SEL_W]))
		else $error("select field not taken from write");

	a_step_follows_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_ctrl_write |=> ref_step_fine == $past(pwdata[CTRL_FINE]))
		else $error("step control not taken from write");

	a_capture_at_tap: assert property (@(posedge ref_clk) disable iff (!resetn)
		$past(resetn) |-> ref_captured == $past(tap_rise[ref_sample_select]))
		else $error("capture not at selected tap");

	a_fall_single_only: assert property (@(posedge ref_clk) disable iff (!resetn)
		ref_capture_fall |-> $past(st_reg.single))
		else $error("falling-edge capture outside single-channel mode");

	a_status_read: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_status_read |=> pready && prdata[NPOS-1:0] == $past(pos_vec) && prdata[31:25] == 7'h00)
		else $error("status read data mismatch");

	a_read_no_effect: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_status_read |=> $stable(ref_sample_select) && $stable(ref_step_fine))
		else $error("status read changed control state");

	a_ready_one_cycle: assert property (@(posedge ref_clk) disable iff (!resetn)
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("apb ready not a single cycle");
endmodule // srwc_top
`default_nettype wire

// >>> sysref_window_capture_bench.sv
/*
 * Self-checking bench for the window capture top: APB master tasks,
 * one task per scenario, and the pulse source model on the taps.
 * Assumes the APB slave answers with a bounded wait.
 */
`timescale 1ns/1ps
`default_nettype none
module sysref_window_capture_bench;
	import srwc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready, pslverr, ref_step_fine, ref_captured, ref_capture_fall;
	logic [3:0]  ref_sample_select;
	logic [23:0] tap_rise, tap_fall;
	logic        run = 1'b0;
	logic [4:0]  edge_pos = 5'h06;
	int          n_fail = 0;
	int          n_checks = 0;
	always #50 ref_clk = ~ref_clk;
	srwc_top i_srwc_top (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tap_rise(tap_rise),
		.tap_fall(tap_fall), .ref_step_fine(ref_step_fine), .ref_sample_select(ref_sample_select),
		.ref_captured(ref_captured), .ref_capture_fall(ref_capture_fall));
	srwc_ref_gen i_srwc_ref_gen (.ref_clk(ref_clk), .resetn(resetn), .run(run), .edge_pos(edge_pos),
		.tap_rise(tap_rise), .tap_fall(tap_fall));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Called just after a rising edge; samples the answer at the ready edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int i;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			n_fail++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wait_rises(input int n);
		int  seen;
		int  k;
		logic last;
		seen = 0;
		last = tap_rise[0];
		for (k = 0; k < 200 && seen < n; k++) begin
			@(posedge ref_clk);
			if (tap_rise[0] && !last)
				seen++;
			last = tap_rise[0];
		end
		if (seen < n) begin
			n_fail++;
			finish_test();
		end
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic check_vec(input int p);
		logic [31:0] rd, rd2;
		logic        e;
		apb(1'b0, OFS_STATUS, 32'h0, rd, e);
		apb(1'b0, OFS_STATUS, 32'h0, rd2, e);
		chk(rd & ~(32'h0000_0003 << (p - 1)), 32'h0180_0001);
		chk({31'h0, |rd[p -: 2]}, 32'h1);
		chk(rd2, rd);
	endtask
	task automatic t_reset();
		logic [31:0] rd;
		logic        e;
		apb(1'b0, OFS_CTRL, 32'h0, rd, e);
		chk(rd, 32'h0000_0000);
		apb(1'b0, OFS_STATUS, 32'h0, rd, e);
		chk(rd, 32'h00FF_FFFF);
		apb(1'b0, 12'h008, 32'h0, rd, e);
		chk({rd[30:0], e}, 32'h0000_0001);
		$display("test reset done");
	endtask
	task automatic t_valid();
		logic [31:0] rd;
		logic        e;
		run <= 1'b1;
		wait_rises(2);
		apb(1'b0, OFS_STATUS, 32'h0, rd, e);
		chk({31'h0, rd[STAT_VALID]}, 32'h0);
		wait_rises(1);
		check_vec(6);
		edge_pos <= 5'h0C;
		wait_rises(6);
		check_vec(12);
		$display("test detector done");
	endtask
	task automatic t_select();
		logic [31:0] rd;
		logic        e;
		logic [1:0]  prev;
		apb(1'b1, OFS_CTRL, 32'h0000_003F, rd, e);
		chk({26'h0, ref_step_fine, ref_sample_select, e}, 32'h0000_003E);
		apb(1'b1, OFS_STATUS, 32'h0000_0000, rd, e);
		chk({31'h0, e}, 32'h0);
		apb(1'b1, 12'h00C, 32'h0000_0000, rd, e);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, OFS_CTRL, 32'h0, rd, e);
		chk(rd, 32'h0000_003F);
		prev = {tap_fall[15], tap_rise[15]};
		repeat (16) begin
			@(posedge ref_clk);
			chk({30'h0, ref_capture_fall, ref_captured}, {30'h0, prev});
			prev = {tap_fall[15], tap_rise[15]};
		end
		// Flags at 0 and 11 with the edge at 12: middle, lower side, coarse at 10 MHz
		apb(1'b1, OFS_CTRL, 32'h0000_0005, rd, e);
		chk({27'h0, ref_step_fine, ref_sample_select}, 32'h0000_0005);
		repeat (2) @(posedge ref_clk);
		prev = {1'b0, tap_rise[5]};
		@(posedge ref_clk);
		chk({30'h0, ref_capture_fall, ref_captured}, {30'h0, prev});
		$display("test select done");
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_valid();
		t_select();
		finish_test();
	end
endmodule // sysref_window_capture_bench
`default_nettype wire
